// ==== inc/cpm_consts.vh ====
// constants of the cpu clock and power mode unit
`ifndef CPM_CONSTS_VH
`define CPM_CONSTS_VH

// register indexes; byte address is four times the index
`define CPM_IDX_POWER_CONTROL 12'h087
`define CPM_IDX_FETCH_WAIT 12'h08e
`define CPM_IDX_DIV_SELECT 12'h0e5
`define CPM_IDX_COMMIT 12'h0e6
`define CPM_IDX_STATUS 12'h0f0
`define CPM_ADDR_W 12

// power_control fields
`define CPM_PC_IDLE 0
`define CPM_PC_STOP 1
`define CPM_PC_GF0 2
`define CPM_PC_RESET 8'h00

// fetch_wait_control fields
`define CPM_FW_LSB 4
`define CPM_FW_MSB 6
`define CPM_FW_RESET 3'h7

// cpu_clock_divider_select
`define CPM_DIV_RESET 3'h7
`define CPM_COMMIT_CODE 8'h69

// axi responses
`define CPM_RESP_OKAY 2'h0
`define CPM_RESP_SLVERR 2'h2

// warm-up: fast oscillator clocks plus slow oscillator clocks
`define CPM_WARM_RESET_FAST 12'h800
`define CPM_WARM_WAKE_FAST 12'h040
`define CPM_WARM_SLOW 3'h5
// typical wake time in us at the fast oscillator rate
`define CPM_WARM_WAKE_TIME_US 315

// power states, one-hot
`define CPM_ST_WARM 5'h01
`define CPM_ST_RUN 5'h02
`define CPM_ST_IDLE 5'h04
`define CPM_ST_STOP 5'h08
`define CPM_ST_WAKE 5'h10

`endif

// ==== design/cpm_clk_div.v ====
// cpu clock divider producing a glitch-free cpu clock enable
`timescale 1ns/1ps
`include "cpm_consts.vh"

module cpm_clk_div (
   input wire clk,
   input wire arst_n,
   input wire run,
   input wire [2:0] code,
   output reg tick_reg,
   output reg [2:0] code_reg
);

   reg [6:0] cnt_reg;
   wire [6:0] mask;

   // code 000 divides by 128, code 111 by 1
   assign mask = (7'h7f >> code_reg);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 7'h00;
         tick_reg <= 1'b0;
         code_reg <= `CPM_DIV_RESET;
      end else if (!run) begin
         // gated: new ratio may load at once, no period is cut short
         cnt_reg <= 7'h00;
         tick_reg <= 1'b0;
         code_reg <= code;
      end else if (cnt_reg == mask) begin
         cnt_reg <= 7'h00;
         tick_reg <= 1'b1;
         code_reg <= code; // RULE_18
      end else begin
         cnt_reg <= cnt_reg + 7'h01;
         tick_reg <= 1'b0;
      end
   end

endmodule

// ==== design/cpm_warmup.v ====
// oscillator warm-up counter: fast clocks then slow oscillator clocks
`timescale 1ns/1ps
`include "cpm_consts.vh"

module cpm_warmup (
   input wire clk,
   input wire arst_n,
   input wire start,
   input wire slow_tick,
   output reg busy_reg,
   output reg done_reg
);

   reg [11:0] fast_reg;
   reg [2:0] slow_reg;
   reg slow_phase_reg;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // reset release starts the long warm-up
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
         fast_reg <= `CPM_WARM_RESET_FAST; // RULE_12
         slow_reg <= `CPM_WARM_SLOW;
         slow_phase_reg <= 1'b0;
      end else if (start) begin
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
         fast_reg <= `CPM_WARM_WAKE_FAST; // RULE_13
         slow_reg <= `CPM_WARM_SLOW;
         slow_phase_reg <= 1'b0;
      end else if (busy_reg && !slow_phase_reg) begin
         done_reg <= 1'b0;
         if (fast_reg == 12'h001) begin
            slow_phase_reg <= 1'b1;
         end
         fast_reg <= fast_reg - 12'h001;
      end else if (busy_reg) begin
         if (slow_tick) begin
            if (slow_reg == 3'h1) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
            slow_reg <= slow_reg - 3'h1;
         end
      end else begin
         done_reg <= 1'b0;
      end
   end

endmodule

// ==== design/cpm_power_unit.v ====
// clock and power mode unit with axi4-lite registers
`timescale 1ns/1ps
`include "cpm_consts.vh"

// Functional notes
// RULE_01 - idle bit0, stop bit1 drive power state
// RULE_02 - idle gates cpu clock only
// RULE_03 - idle wakes on port change or interrupt
// RULE_04 - idle wake clears idle bit
// RULE_05 - stop halts cpu, peripherals, oscillator
// RULE_06 - stop wakes on port change only
// RULE_07 - stop wake clears stop bit
// RULE_08 - after reset run at divided cpu clock
// RULE_09 - divider codes 000..111 give 128..1
// RULE_10 - divider applies only on 0x69 commit
// RULE_11 - fetch wait inserts 0..7 extra cycles
// RULE_12 - reset warm-up 2048 fast plus 5 slow
// RULE_13 - stop wake warm-up 64 fast plus 5 slow
// RULE_14 - single internal fast oscillator source
// RULE_15 - interrupt wakes only when both enabled
// RULE_16 - fixed oscillator feeds the divider
// RULE_17 - other commit values change nothing
// RULE_18 - cpu clock gated during warm-up, clean release
module cpm_power_unit (
   input wire clk,
   input wire arst_n,
   input wire slow_osc_tick,
   input wire [7:0] port_zero,
   input wire [7:0] port_one,
   input wire global_interrupt_enable,
   input wire [7:0] irq_request,
   input wire [7:0] irq_enable,
   input wire fetch_req,
   output reg fetch_ack_reg,
   output reg cpu_clk_en_reg,
   output reg periph_clk_en_reg,
   output reg fast_osc_run_reg,
   output reg [4:0] power_state_reg,
   input wire [`CPM_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`CPM_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   reg [7:0] pwr_ctrl_reg;
   reg [2:0] fetch_wait_reg;
   reg [2:0] div_sel_reg;
   reg [7:0] port_zero_prev_reg;
   reg [7:0] port_one_prev_reg;
   reg [2:0] fetch_cnt_reg;
   reg [`CPM_ADDR_W-1:0] aw_addr_reg;
   reg aw_held_reg;
   reg [31:0] w_data_reg;
   reg w_strb_reg;
   reg w_held_reg;
   reg [4:0] state_next;
   reg [7:0] pwr_ctrl_next;
   reg [31:0] rd_data;
   reg rd_hit;
   reg warm_start;

   wire [`CPM_ADDR_W-1:0] aw_idx;
   wire [`CPM_ADDR_W-1:0] ar_idx;
   wire wr_fire;
   wire wr_hit;
   wire port_change;
   wire irq_wake;
   wire cpu_tick;
   wire [2:0] active_code;
   wire warm_busy;
   wire warm_done;
   wire div_run;

   // byte address to register index, low two bits ignored
   assign aw_idx = {2'b00, aw_addr_reg[`CPM_ADDR_W-1:2]};
   assign ar_idx = {2'b00, s_axi_araddr[`CPM_ADDR_W-1:2]};
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_hit = (aw_idx == `CPM_IDX_POWER_CONTROL) ||
                   (aw_idx == `CPM_IDX_FETCH_WAIT) ||
                   (aw_idx == `CPM_IDX_DIV_SELECT) ||
                   (aw_idx == `CPM_IDX_COMMIT);

   // inputs are synchronous; any bit that differs from last cycle counts
   assign port_change = (|(port_zero ^ port_zero_prev_reg)) ||
                        (|(port_one ^ port_one_prev_reg));
   assign irq_wake = global_interrupt_enable &&
                     (|(irq_request & irq_enable)); // RULE_15

   // the fast oscillator is the only source, so clk is fosc itself
   assign div_run = (power_state_reg == `CPM_ST_RUN); // RULE_16 RULE_14

   cpm_clk_div u_div (
      .clk (clk),
      .arst_n (arst_n),
      .run (div_run),
      .code (active_code),
      .tick_reg (cpu_tick),
      .code_reg ()
   );

   cpm_warmup u_warm (
      .clk (clk),
      .arst_n (arst_n),
      .start (warm_start),
      .slow_tick (slow_osc_tick),
      .busy_reg (warm_busy),
      .done_reg (warm_done)
   );

   // committed ratio, separate from the software selection
   reg [2:0] commit_code_reg;
   assign active_code = commit_code_reg;

   // power state and hardware clearing of the mode bits
   always @* begin
      state_next = power_state_reg;
      pwr_ctrl_next = pwr_ctrl_reg;
      warm_start = 1'b0;
      case (power_state_reg)
         `CPM_ST_WARM: begin
            if (warm_done) begin
               state_next = `CPM_ST_RUN; // RULE_08
            end
         end
         `CPM_ST_RUN: begin
            if (pwr_ctrl_reg[`CPM_PC_STOP]) begin
               state_next = `CPM_ST_STOP; // RULE_01 RULE_05
            end else if (pwr_ctrl_reg[`CPM_PC_IDLE]) begin
               state_next = `CPM_ST_IDLE; // RULE_01 RULE_02
            end
         end
         `CPM_ST_IDLE: begin
            if (port_change || irq_wake) begin
               state_next = `CPM_ST_RUN; // RULE_03
               pwr_ctrl_next[`CPM_PC_IDLE] = 1'b0; // RULE_04
            end
         end
         `CPM_ST_STOP: begin
            if (port_change) begin
               state_next = `CPM_ST_WAKE; // RULE_06
               pwr_ctrl_next[`CPM_PC_STOP] = 1'b0; // RULE_07
               warm_start = 1'b1; // RULE_13
            end
         end
         `CPM_ST_WAKE: begin
            if (warm_done && !warm_start) begin
               state_next = `CPM_ST_RUN; // RULE_18
            end
         end
         default: begin
            state_next = `CPM_ST_WARM;
         end
      endcase
      // a software write lands after the hardware clear
      if (wr_fire && w_strb_reg && aw_idx == `CPM_IDX_POWER_CONTROL) begin
         pwr_ctrl_next = {5'h00, w_data_reg[2:0]};
      end
   end

   // state, registers and clock enables
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_state_reg <= `CPM_ST_WARM;
         pwr_ctrl_reg <= `CPM_PC_RESET;
         fetch_wait_reg <= `CPM_FW_RESET; // RULE_11
         div_sel_reg <= `CPM_DIV_RESET; // RULE_09
         commit_code_reg <= `CPM_DIV_RESET;
         port_zero_prev_reg <= 8'h00;
         port_one_prev_reg <= 8'h00;
         cpu_clk_en_reg <= 1'b0;
         periph_clk_en_reg <= 1'b0;
         fast_osc_run_reg <= 1'b1;
      end else begin
         power_state_reg <= state_next;
         pwr_ctrl_reg <= pwr_ctrl_next;
         port_zero_prev_reg <= port_zero;
         port_one_prev_reg <= port_one;
         if (wr_fire && w_strb_reg) begin
            if (aw_idx == `CPM_IDX_FETCH_WAIT) begin
               fetch_wait_reg <= w_data_reg[`CPM_FW_MSB:`CPM_FW_LSB];
            end
            if (aw_idx == `CPM_IDX_DIV_SELECT) begin
               div_sel_reg <= w_data_reg[2:0];
            end
            if (aw_idx == `CPM_IDX_COMMIT &&
                w_data_reg[7:0] == `CPM_COMMIT_CODE) begin
               commit_code_reg <= div_sel_reg; // RULE_10 RULE_17
            end
         end
         // cpu enable follows the divider, which only runs in RUN
         // no pulse on the edge that leaves run, so idle starts gated
         cpu_clk_en_reg <= cpu_tick && div_run && // RULE_02 RULE_18
                           (state_next == `CPM_ST_RUN);
         periph_clk_en_reg <= (state_next == `CPM_ST_RUN) ||
                              (state_next == `CPM_ST_IDLE); // RULE_05
         fast_osc_run_reg <= (state_next != `CPM_ST_STOP); // RULE_05
      end
   end

   // program fetch: ack after fetch_wait_reg extra cpu cycles
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_cnt_reg <= 3'h0;
         fetch_ack_reg <= 1'b0;
      end else begin
         fetch_ack_reg <= 1'b0;
         if (fetch_req && cpu_tick && div_run && !fetch_ack_reg) begin
            if (fetch_cnt_reg == fetch_wait_reg) begin
               fetch_cnt_reg <= 3'h0;
               fetch_ack_reg <= 1'b1; // RULE_11
            end else begin
               fetch_cnt_reg <= fetch_cnt_reg + 3'h1;
            end
         end
      end
   end

   // axi4-lite write: address and data taken in either order
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CPM_RESP_OKAY;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= {`CPM_ADDR_W{1'b0}};
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb[0];
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read decode; the commit register is write-only and reads zero
   always @* begin
      rd_data = 32'h00000000;
      rd_hit = 1'b1;
      case (ar_idx)
         `CPM_IDX_POWER_CONTROL: rd_data = {24'h000000, pwr_ctrl_reg};
         `CPM_IDX_FETCH_WAIT: rd_data = {25'h0, fetch_wait_reg, 4'h0};
         `CPM_IDX_DIV_SELECT: rd_data = {29'h0, div_sel_reg};
         `CPM_IDX_COMMIT: rd_data = 32'h00000000;
         `CPM_IDX_STATUS: rd_data = {17'h00000, commit_code_reg, 3'h0,
                                     warm_busy, 3'h0, power_state_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   // axi4-lite read: one outstanding, answer one cycle after ar
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `CPM_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ==== test/cpm_power_unit_checker.sv ====
// port assertions for the clock and power mode unit
`timescale 1ns/1ps
`include "cpm_consts.vh"
module cpm_power_unit_checker (
   input wire clk,
   input wire arst_n,
   input wire [7:0] port_zero,
   input wire [7:0] port_one,
   input wire global_interrupt_enable,
   input wire [7:0] irq_request,
   input wire [7:0] irq_enable,
   input wire fetch_ack_reg,
   input wire cpu_clk_en_reg,
   input wire periph_clk_en_reg,
   input wire fast_osc_run_reg,
   input wire [4:0] power_state_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [11:0] cnt_reg;
   logic [4:0] last_reg;
   wire idle = power_state_reg == `CPM_ST_IDLE;
   wire stop = power_state_reg == `CPM_ST_STOP;
   wire wake_irq = global_interrupt_enable && |(irq_request & irq_enable);
   // counts how long the previous state was held, for the warm-up bounds
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 12'h000;
         last_reg <= `CPM_ST_WARM;
      end else begin
         last_reg <= power_state_reg;
         cnt_reg <= power_state_reg == last_reg ? cnt_reg + 12'h001 : 12'h001;
      end
   end
   a_idle_gates_cpu: assert property (
      idle |-> !cpu_clk_en_reg && periph_clk_en_reg && fast_osc_run_reg)
      else $error("idle gating wrong");
   a_stop_halts_all: assert property (
      stop |-> !cpu_clk_en_reg && !periph_clk_en_reg && !fast_osc_run_reg)
      else $error("stop gating wrong");
   a_cpu_run_only: assert property (
      cpu_clk_en_reg |-> power_state_reg == `CPM_ST_RUN)
      else $error("cpu clock outside run");
   a_idle_port_wake: assert property (
      idle && !($stable(port_zero) && $stable(port_one))
      |=> power_state_reg == `CPM_ST_RUN) else $error("idle port wake");
   a_idle_irq_wake: assert property (
      idle && wake_irq |=> power_state_reg == `CPM_ST_RUN)
      else $error("idle irq wake");
   a_idle_holds: assert property (
      idle && $stable(port_zero) && $stable(port_one) && !wake_irq
      |=> idle) else $error("idle left without cause");
   a_stop_no_irq: assert property (
      stop && $stable(port_zero) && $stable(port_one) |=> stop)
      else $error("stop left without port change");
   a_stop_port_wake: assert property (
      stop && !($stable(port_zero) && $stable(port_one))
      |=> power_state_reg == `CPM_ST_WAKE) else $error("stop port wake");
   a_warm_length: assert property (
      last_reg == `CPM_ST_WARM && power_state_reg == `CPM_ST_RUN
      |-> cnt_reg >= 12'h805) else $error("reset warm-up short");
   a_wake_length: assert property (
      last_reg == `CPM_ST_WAKE && power_state_reg == `CPM_ST_RUN
      |-> cnt_reg >= 12'h045) else $error("stop wake-up short");
   a_ack_one_cycle: assert property (
      fetch_ack_reg |=> !fetch_ack_reg) else $error("fetch ack too long");
   c_wake_done: cover property (last_reg == `CPM_ST_WAKE && !stop);
   c_idle_irq: cover property (idle && wake_irq);
   c_fetch: cover property (fetch_ack_reg);
endmodule
bind cpm_power_unit cpm_power_unit_checker u_cpm_power_unit_checker (
   .clk, .arst_n, .port_zero, .port_one, .global_interrupt_enable,
   .irq_request, .irq_enable, .fetch_ack_reg, .cpu_clk_en_reg,
   .periph_clk_en_reg, .fast_osc_run_reg, .power_state_reg);

// ==== test/cpm_cpu_model.sv ====
// processor side model: issues fetches and counts cpu clock ticks
`timescale 1ns/1ps
module cpm_cpu_model (
   input wire clk,
   input wire arst_n,
   input wire cpu_clk_en,
   input wire fetch_ack,
   input wire go,
   output logic fetch_req,
   output logic [7:0] ticks
);
   logic armed;
   // the core holds its request until acknowledged, never drops it early;
   // a cpu enable already launched when the request rose is not counted
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_req <= 1'b0;
         ticks <= 8'h00;
         armed <= 1'b0;
      end else begin
         armed <= fetch_req;
         if (fetch_req) begin
            if (cpu_clk_en && armed) begin
               ticks <= ticks + 8'h01;
            end
            if (fetch_ack) begin
               fetch_req <= 1'b0;
            end
         end else if (go) begin
            fetch_req <= 1'b1;
            ticks <= 8'h00;
         end
      end
   end
endmodule

// ==== test/test_cpm_power_unit.sv ====
// self-checking bench for the clock and power mode unit
`timescale 1ns/1ps
`include "cpm_consts.vh"
module test_cpm_power_unit;
   logic clk = 1'b0, arst_n = 1'b0, slow_osc_tick = 1'b0, gie = 1'b0;
   logic [7:0] port_zero = 8'h00, port_one = 8'h00;
   logic [7:0] irq_request = 8'h00, irq_enable = 8'h00;
   logic go = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, seed = 32'hdaf37ebc;
   logic fetch_req, fetch_ack_reg, cpu_clk_en_reg, periph_clk_en_reg;
   logic fast_osc_run_reg, awready, wready, bvalid, arready, rvalid;
   logic [4:0] power_state_reg;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] ticks;
   logic [2:0] sc = 3'h0;
   int bad_count = 0, checks = 0;
   cpm_power_unit u_cpm_power_unit (.clk, .arst_n, .slow_osc_tick,
      .port_zero, .port_one, .global_interrupt_enable(gie), .irq_request,
      .irq_enable, .fetch_req, .fetch_ack_reg, .cpu_clk_en_reg,
      .periph_clk_en_reg, .fast_osc_run_reg, .power_state_reg,
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   cpm_cpu_model u_cpm_cpu_model (.clk, .arst_n, .cpu_clk_en(cpu_clk_en_reg),
      .fetch_ack(fetch_ack_reg), .go, .fetch_req, .ticks);
   initial begin
      forever #5 clk = ~clk;
   end
   // slow oscillator tick every 8 clocks keeps the warm-up runs short
   always @(posedge clk) begin
      sc <= sc + 3'h1;
      slow_osc_tick <= sc == 3'h7;
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function int period(input int c);
      return 1 << (7 - c);
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t saw %h want %h", $time, s, e);
      end
   endtask
   task wr(input logic [11:0] i, input logic [7:0] d);
      @(posedge clk);
      awaddr <= {i[9:0], 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task rc(input logic [11:0] i, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= {i[9:0], 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask
   task wst(input logic [4:0] s, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (power_state_reg !== s && n < 5000);
   endtask
   task per(output int p);
      p = 0;
      do @(negedge clk); while (cpu_clk_en_reg !== 1'b1);
      do begin
         @(negedge clk);
         p++;
      end while (cpu_clk_en_reg !== 1'b1 && p < 300);
   endtask
   task stop_test();
      if (bad_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      stop_test();
   end
   initial begin
      int n, p, old;
      logic [31:0] r;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      wst(`CPM_ST_RUN, n);
      chk(n >= 2053 && n <= 2110, 1);
      rc(`CPM_IDX_FETCH_WAIT, 32'h70, `CPM_RESP_OKAY);
      rc(`CPM_IDX_DIV_SELECT, 32'h7, `CPM_RESP_OKAY);
      rc(`CPM_IDX_POWER_CONTROL, 32'h0, `CPM_RESP_OKAY);
      rc(`CPM_IDX_COMMIT, 32'h0, `CPM_RESP_OKAY);
      rc(12'h001, 32'h0, `CPM_RESP_SLVERR);
      rc(`CPM_IDX_STATUS, 32'h7002, `CPM_RESP_OKAY);
      wr(12'h001, 8'h00);
      chk({30'h0, bresp}, {30'h0, `CPM_RESP_SLVERR});
      old = 1;
      for (int c = 0; c < 8; c++) begin
         r = rnd();
         wr(`CPM_IDX_DIV_SELECT, c[7:0]);
         wr(`CPM_IDX_COMMIT, r[7:0] == 8'h69 ? 8'h96 : r[7:0]);
         per(p);
         chk(p, old);
         wr(`CPM_IDX_COMMIT, `CPM_COMMIT_CODE);
         chk({30'h0, bresp}, {30'h0, `CPM_RESP_OKAY});
         per(p);
         per(p);
         old = period(c);
         chk(p, old);
         wr(`CPM_IDX_FETCH_WAIT, {1'b0, r[10:8], 4'h0});
         @(posedge clk);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         do @(negedge clk); while (fetch_ack_reg !== 1'b1);
         @(negedge clk);
         chk(ticks, {29'h0, r[10:8]} + 32'h1);
      end
      @(posedge clk);
      irq_enable <= 8'hff;
      wr(`CPM_IDX_POWER_CONTROL, 8'h01);
      wst(`CPM_ST_IDLE, n);
      @(posedge clk);
      irq_request <= 8'h01 << r[2:0];
      repeat (4) @(negedge clk);
      chk(power_state_reg, `CPM_ST_IDLE);
      @(posedge clk);
      gie <= 1'b1;
      wst(`CPM_ST_RUN, n);
      chk(n <= 3, 1);
      rc(`CPM_IDX_POWER_CONTROL, 32'h0, `CPM_RESP_OKAY);
      irq_request <= 8'h00;
      wr(`CPM_IDX_POWER_CONTROL, 8'h01);
      wst(`CPM_ST_IDLE, n);
      @(posedge clk);
      port_one <= port_one ^ (8'h01 << r[5:3]);
      wst(`CPM_ST_RUN, n);
      chk(n <= 3, 1);
      rc(`CPM_IDX_POWER_CONTROL, 32'h0, `CPM_RESP_OKAY);
      irq_request <= 8'h01;
      wr(`CPM_IDX_POWER_CONTROL, 8'h02);
      wst(`CPM_ST_STOP, n);
      repeat (8) @(negedge clk);
      chk(power_state_reg, `CPM_ST_STOP);
      chk(fast_osc_run_reg, 0);
      @(posedge clk);
      port_zero <= port_zero ^ (8'h01 << r[13:11]);
      wst(`CPM_ST_WAKE, n);
      wst(`CPM_ST_RUN, n);
      chk(n >= 64 && n <= 120, 1);
      rc(`CPM_IDX_POWER_CONTROL, 32'h0, `CPM_RESP_OKAY);
      stop_test();
   end
endmodule
